/* include/vsp_map.svh */
// Purpose: Offsets, field positions, reset values of the sync/blink register bank
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef VSP_MAP_SVH
`define VSP_MAP_SVH

// Register indices
`define VSP_IDX_SYNC_PWM     8'h23
`define VSP_IDX_BLINK        8'h33
`define VSP_IDX_SYNC_POL     8'h34
`define VSP_IDX_EVT_STATUS   8'h40
`define VSP_IDX_EVT_MASK     8'h41

// Sync interrupt and PWM polarity fields
`define VSP_BIT_SRC_FLAG     7
`define VSP_BIT_VS_IEN       6
`define VSP_BIT_PWM_CHANNEL_EIGHT_INV     2
`define VSP_BIT_LOW_INV      1
`define VSP_BIT_HIGH_INV     0
`define VSP_SYNC_PWM_WMASK   8'hC7

// Blink control fields
`define VSP_BLINK_RATIO_LSB  2
`define VSP_BLINK_FREQ_LSB   0
`define VSP_BLINK_WMASK      8'h0F

// Sync polarity field
`define VSP_BIT_VS_POL       2

// Event status bits
`define VSP_EVT_VSYNC        0
`define VSP_EVT_BLINK        1
`define VSP_EVT_WMASK        8'h03

// Reset values
`define VSP_RST_SYNC_PWM     8'h00
`define VSP_RST_BLINK        8'h03
`define VSP_RST_SYNC_POL     8'h00
`define VSP_RST_EVT_MASK     8'h00

// Shared interrupt vector address
`define VSP_SHARED_VECTOR    8'h05

// Blink timing in sync edges
`define VSP_BLINK_BASE       16

`endif

/* include/vsp_pkg.sv */
// Purpose: Types of the sync/blink register bank
// Assumes: Used with vsp_map.svh
// Notes:   APB state encoding is one-hot; ratio codes are binary
package vsp_pkg;

    typedef enum logic [1:0]
    {
        VSP_APB_SETUP  = 2'b01,
        VSP_APB_ACCESS = 2'b10
    } vsp_apb_state_t;

    typedef enum logic [1:0]
    {
        VSP_RATIO_3_1  = 2'b00,
        VSP_RATIO_1_1  = 2'b01,
        VSP_RATIO_1_3  = 2'b10,
        VSP_RATIO_RSVD = 2'b11
    } vsp_ratio_t;

endpackage

/* verilog/vsp_vsync_edge.sv */
// Purpose: Synchronise the sync pin and find its active edge
// Assumes: Pin is asynchronous to core_clk
// Notes:   One-cycle pulse on entry into the active level
`timescale 1ns/10ps
`default_nettype none
module vsp_vsync_edge
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Pin and polarity
    input  wire logic vertical_sync_in,
    input  wire logic vsync_polarity_sel,
    // Event
    output logic      active_edge
);
    logic sync_a;
    logic sync_b;
    logic active_d;
    logic active_now;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= vertical_sync_in;
            sync_b <= sync_a;
        end
    end

    // Low-active pin when polarity is 0
    assign active_now = vsync_polarity_sel ? sync_b : ~sync_b;

    // Polarity change can fake one edge; software sets it once
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            active_d <= 1'b1;
        else
            active_d <= active_now;
    end

    assign active_edge = active_now & ~active_d;

endmodule
`default_nettype wire

/* verilog/vsp_blink_gen.sv */
// Purpose: Blink period and on/off phase from sync edges
// Assumes: tick is a one-cycle pulse per active sync edge
// Notes:   Visible first, then hidden, within each period
`timescale 1ns/10ps
`default_nettype none
`include "vsp_map.svh"
module vsp_blink_gen
    import vsp_pkg::*;
#(
    parameter int CNT_W = 7
)
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       tick,
    input  wire logic [1:0] freq_sel,
    input  wire logic [1:0] ratio_sel,
    // Results
    output logic            blink_visible,
    output logic            period_wrap
);
    logic [CNT_W-1:0] edge_cnt;
    logic [CNT_W-1:0] last_cnt;
    logic [CNT_W-1:0] on_len;
    logic [CNT_W:0]   period;

    assign period   = (CNT_W+1)'(`VSP_BLINK_BASE) << freq_sel;
    assign last_cnt = CNT_W'(period - 1'b1);

    always_comb
    begin
        case (vsp_ratio_t'(ratio_sel))
            VSP_RATIO_3_1: on_len = CNT_W'((period >> 1) + (period >> 2));
            VSP_RATIO_1_1: on_len = CNT_W'(period >> 1);
            VSP_RATIO_1_3: on_len = CNT_W'(period >> 2);
            // Reserved code behaves as 1:1
            default:       on_len = CNT_W'(period >> 1);
        endcase
    end

    // Shortened period restarts count rather than overrun
    assign period_wrap = tick & (edge_cnt >= last_cnt); // [RULE_15]

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            edge_cnt <= '0;
        else if (period_wrap)
            edge_cnt <= '0;
        else if (tick)
            edge_cnt <= edge_cnt + 1'b1; // [RULE_15]
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            blink_visible <= 1'b1;
        else
            blink_visible <= (edge_cnt < on_len); // [RULE_12] [RULE_13]
    end

endmodule
`default_nettype wire

/* verilog/vsp_top.sv */
// Purpose: Sync interrupt, PWM polarity and blink control register bank
// Assumes: APB slave on core_clk, no wait states, ready in the first access cycle
// Notes:   Serial interrupt request and enable come from on-chip logic
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "vsp_map.svh"

// Summary of operation
// RULE_01 - Flag bit 7: 1 sync, 0 serial
// RULE_02 - Both sources share vector 05H
// RULE_03 - Software clears flag after service
// RULE_04 - Sync interrupt needs serial enable and bit 6
// RULE_05 - Sync interrupt on selected sync edge
// RULE_06 - Software picks polarity for retrace start
// RULE_07 - Polarity bit: 0 active low, 1 high
// RULE_08 - Bit 2 inverts eighth PWM channel
// RULE_09 - Bit 1 inverts channels zero to three
// RULE_10 - Bit 0 inverts channels four to seven
// RULE_11 - Bits 5 to 3 reserved, no effect
// RULE_12 - Ratio field selects 3:1, 1:1, 1:3
// RULE_13 - Frequency field divides sync by 16..128
// RULE_14 - Upper blink bits reserved, no effect
// RULE_15 - Blink period counts active sync edges
module vsp_top
    import vsp_pkg::*;
#(
    parameter int PWM_N = 8,
    parameter int CNT_W = 7
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Sync pin
    input  wire logic             vertical_sync_in,
    // Serial interface interrupt
    input  wire logic             serial_irq_req,
    input  wire logic             serial_irq_enable,
    // Shared CPU interrupt
    output logic                  shared_irq,
    output logic [7:0]            shared_irq_vector,
    // PWM channels
    input  wire logic [PWM_N-1:0] pwm_raw,
    input  wire logic             pwm_channel_eight,
    output logic [PWM_N-1:0]      pwm_out,
    output logic                  pwm_eight_out,
    // Character blink
    output logic                  blink_visible,
    // Event interrupt
    output logic                  evt_irq
);
    vsp_apb_state_t apb_state;
    vsp_apb_state_t next_apb_state;

    logic [7:0] sync_pwm;
    logic [7:0] blink_ctrl;
    logic [7:0] sync_pol;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;

    logic       irq_source_flag;
    logic       vsync_irq_enable;
    logic       pwm_ch8_invert;
    logic       pwm_low_group_invert;
    logic       pwm_high_group_invert;
    logic       vsync_polarity_sel;
    logic [1:0] blink_freq;
    logic [1:0] blink_ratio;

    logic       vsync_edge;
    logic       vsync_event;
    logic       blink_wrap;
    logic       blink_vis_int;

    logic       xfer_done;
    logic       wr_en;
    logic       rd_en;
    logic       lane0;
    logic [7:0] wbyte;
    logic [7:0] evt_set;
    logic [7:0] evt_clr;
    logic [7:0] rd_byte;
    logic       hit;
    logic       wr_sync_pwm;
    logic       wr_blink;
    logic       wr_sync_pol;
    logic       wr_evt_mask;
    logic       rd_evt_status;
    logic       rd_setup;

    // Index decode, shared by read mux and write strobes
    function automatic logic sel_idx(input logic [11:0] addr, input logic [7:0] idx);
        sel_idx = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
    endfunction

    function automatic logic addr_known(input logic [11:0] addr);
        addr_known = sel_idx(addr, `VSP_IDX_SYNC_PWM)
                   | sel_idx(addr, `VSP_IDX_BLINK)
                   | sel_idx(addr, `VSP_IDX_SYNC_POL)
                   | sel_idx(addr, `VSP_IDX_EVT_STATUS)
                   | sel_idx(addr, `VSP_IDX_EVT_MASK);
    endfunction

    // Field views
    assign irq_source_flag       = sync_pwm[`VSP_BIT_SRC_FLAG];
    assign vsync_irq_enable      = sync_pwm[`VSP_BIT_VS_IEN];
    assign pwm_ch8_invert        = sync_pwm[`VSP_BIT_PWM_CHANNEL_EIGHT_INV];
    assign pwm_low_group_invert  = sync_pwm[`VSP_BIT_LOW_INV];
    assign pwm_high_group_invert = sync_pwm[`VSP_BIT_HIGH_INV];
    assign vsync_polarity_sel    = sync_pol[`VSP_BIT_VS_POL];
    assign blink_ratio           = blink_ctrl[`VSP_BLINK_RATIO_LSB +: 2];
    assign blink_freq            = blink_ctrl[`VSP_BLINK_FREQ_LSB +: 2];

    // APB handshake: setup, then one access cycle with pready
    always_comb
    begin
        case (apb_state)
            VSP_APB_SETUP:
                next_apb_state = (psel && !penable) ? VSP_APB_ACCESS : VSP_APB_SETUP;
            VSP_APB_ACCESS:
                next_apb_state = VSP_APB_SETUP;
            default:
                next_apb_state = VSP_APB_SETUP;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            apb_state <= VSP_APB_SETUP;
        else
            apb_state <= next_apb_state;
    end

    assign pready    = (apb_state == VSP_APB_ACCESS);
    assign xfer_done = psel & penable & pready;
    assign wr_en     = xfer_done & pwrite;
    assign rd_en     = xfer_done & ~pwrite;
    assign lane0     = pstrb[0];
    assign wbyte     = pwdata[7:0];
    assign hit       = addr_known(paddr);

    // Per-register strobes, a write needs byte lane 0
    assign wr_sync_pwm   = wr_en & lane0 & sel_idx(paddr, `VSP_IDX_SYNC_PWM);
    assign wr_blink      = wr_en & lane0 & sel_idx(paddr, `VSP_IDX_BLINK);
    assign wr_sync_pol   = wr_en & lane0 & sel_idx(paddr, `VSP_IDX_SYNC_POL);
    assign wr_evt_mask   = wr_en & lane0 & sel_idx(paddr, `VSP_IDX_EVT_MASK);
    assign rd_evt_status = rd_en & sel_idx(paddr, `VSP_IDX_EVT_STATUS);
    assign rd_setup      = psel & ~penable & ~pwrite;

    // Error only on the access edge, low otherwise
    assign pslverr = pready & psel & penable & ~hit;

    // Read data captured in setup so prdata comes from a flop
    always_comb
    begin
        rd_byte = 8'h00;
        if (sel_idx(paddr, `VSP_IDX_SYNC_PWM))
            rd_byte = sync_pwm;
        else if (sel_idx(paddr, `VSP_IDX_BLINK))
            rd_byte = blink_ctrl;
        else if (sel_idx(paddr, `VSP_IDX_SYNC_POL))
            rd_byte = sync_pol;
        else if (sel_idx(paddr, `VSP_IDX_EVT_STATUS))
            rd_byte = evt_status;
        else if (sel_idx(paddr, `VSP_IDX_EVT_MASK))
            rd_byte = evt_mask;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= {24'h00_0000, rd_byte};
    end

    // Sync edge detection with selected polarity
    vsp_vsync_edge u_edge
    (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .vertical_sync_in   (vertical_sync_in),
        .vsync_polarity_sel (vsync_polarity_sel), // [RULE_07]
        .active_edge        (vsync_edge)          // [RULE_05]
    );

    // Sync only interrupts when both enables are set
    assign vsync_event = vsync_edge & serial_irq_enable & vsync_irq_enable; // [RULE_04]

    // Sync interrupt and PWM polarity register
    // Flag set by sync event wins over a software clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            sync_pwm <= `VSP_RST_SYNC_PWM;
        else
        begin
            if (wr_sync_pwm)
                sync_pwm <= wbyte & `VSP_SYNC_PWM_WMASK; // [RULE_11]
            if (vsync_event)
                sync_pwm[`VSP_BIT_SRC_FLAG] <= 1'b1; // [RULE_01]
        end
    end

    // Blink control register, upper nibble held at zero
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            blink_ctrl <= `VSP_RST_BLINK;
        else if (wr_blink)
            blink_ctrl <= wbyte & `VSP_BLINK_WMASK; // [RULE_14]
    end

    // Sync polarity register, only the polarity bit is kept
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            sync_pol <= `VSP_RST_SYNC_POL;
        else if (wr_sync_pol)
            sync_pol <= wbyte & (8'h01 << `VSP_BIT_VS_POL); // [RULE_07]
    end

    // Shared interrupt: a flag left set keeps requesting
    // Serial source is reported with the flag at 0
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            shared_irq <= 1'b0;
        else
            shared_irq <= serial_irq_enable & (irq_source_flag | serial_irq_req); // [RULE_01] [RULE_03]
    end

    assign shared_irq_vector = `VSP_SHARED_VECTOR; // [RULE_02]

    // PWM polarity, registered so outputs come from flops
    genvar gi;
    generate
        for (gi = 0; gi < PWM_N; gi++)
        begin : g_pwm
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                    pwm_out[gi] <= 1'b0;
                else if (gi < PWM_N/2)
                    pwm_out[gi] <= pwm_raw[gi] ^ pwm_low_group_invert; // [RULE_09]
                else
                    pwm_out[gi] <= pwm_raw[gi] ^ pwm_high_group_invert; // [RULE_10]
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pwm_eight_out <= 1'b0;
        else
            pwm_eight_out <= pwm_channel_eight ^ pwm_ch8_invert; // [RULE_08]
    end

    // Blink counts every active edge, regardless of interrupt enables
    vsp_blink_gen #(.CNT_W (CNT_W)) u_blink
    (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .tick          (vsync_edge),    // [RULE_15]
        .freq_sel      (blink_freq),    // [RULE_13]
        .ratio_sel     (blink_ratio),   // [RULE_12]
        .blink_visible (blink_vis_int),
        .period_wrap   (blink_wrap)
    );

    assign blink_visible = blink_vis_int;

    // Event status: sticky, cleared by a read, set wins
    always_comb
    begin
        evt_set = 8'h00;
        evt_set[`VSP_EVT_VSYNC] = vsync_edge;
        evt_set[`VSP_EVT_BLINK] = blink_wrap;
        // Clear only what the read returned; an event after setup survives
        evt_clr = rd_evt_status ? prdata[7:0] : 8'h00;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            evt_status <= 8'h00;
        else
            evt_status <= ((evt_status & ~evt_clr) | evt_set) & `VSP_EVT_WMASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            evt_mask <= `VSP_RST_EVT_MASK;
        else if (wr_evt_mask)
            evt_mask <= wbyte & `VSP_EVT_WMASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            evt_irq <= 1'b0;
        else
            evt_irq <= |(evt_status & evt_mask);
    end

endmodule
`default_nettype wire

/* bench/vsp_top_chk.sv */
// Purpose: Port-level assertions for the sync/blink register bank
// Assumes: One clock domain, synchronous reset
// Notes:   Attached by bind from the bench top file
`timescale 1ns/10ps
`default_nettype none
module vsp_top_chk
#(
    parameter int PWM_N = 8
)
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic [31:0]      prdata,
    input  wire logic             pready,
    input  wire logic             pslverr,
    input  wire logic             serial_irq_req,
    input  wire logic             serial_irq_enable,
    input  wire logic             shared_irq,
    input  wire logic [7:0]       shared_irq_vector,
    input  wire logic [PWM_N-1:0] pwm_raw,
    input  wire logic [PWM_N-1:0] pwm_out,
    input  wire logic             blink_visible,
    input  wire logic             evt_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    vector_fixed_a: assert property (shared_irq_vector == 8'h05)
        else $error("shared vector not fixed");
    irq_gated_a: assert property (!serial_irq_enable |=> !shared_irq)
        else $error("shared irq without serial enable");
    serial_src_a: assert property (serial_irq_enable && serial_irq_req |=> shared_irq)
        else $error("serial request not raised");
    // Group invert must act on all four channels alike
    low_group_a: assert property ((pwm_out[3:0] ^ $past(pwm_raw[3:0])) inside {4'h0, 4'hF})
        else $error("low pwm group split");
    high_group_a: assert property ((pwm_out[7:4] ^ $past(pwm_raw[7:4])) inside {4'h0, 4'hF})
        else $error("high pwm group split");
    wait_state_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");

    cover property (shared_irq && !serial_irq_req);
    cover property (pslverr);
    cover property ($fell(blink_visible));
    cover property (evt_irq);
endmodule
`default_nettype wire

/* bench/vsp_cpu_side.sv */
// Purpose: Far side model: sync pin and serial engine request
// Assumes: Called from the bench right after a rising edge
// Notes:   Pin idles high until told otherwise
`timescale 1ns/10ps
`default_nettype none
module vsp_cpu_side
(
    input  wire logic core_clk,
    output logic      vertical_sync_in,
    output logic      serial_irq_req
);
    initial
    begin
        vertical_sync_in = 1'b1;
        serial_irq_req   = 1'b0;
    end

    task automatic set_sync(input logic lvl);
        vertical_sync_in <= lvl;
    endtask

    task automatic set_serial(input logic req);
        serial_irq_req <= req;
    endtask

    // Pulse level follows programmed polarity so the edge opens retrace
    task automatic pulse(input logic act);
        vertical_sync_in <= act;
        repeat (6) @(posedge core_clk);
        vertical_sync_in <= ~act;
        repeat (4) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

/* bench/vsp_top_bench.sv */
// Purpose: Self-checking bench of the sync/blink register bank
// Assumes: Zero wait state APB slave, registers at four times index
// Notes:   Blink checks count visible edges over whole periods
`timescale 1ns/10ps
`default_nettype none
`include "vsp_map.svh"
module vsync_irq_blink_pwm_polarity_bench;
    import vsp_pkg::*;
    logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        vertical_sync_in, serial_irq_req, serial_irq_enable, shared_irq;
    logic [7:0]  shared_irq_vector, pwm_raw, pwm_out;
    logic        pwm_channel_eight, pwm_eight_out, blink_visible, evt_irq;
    int          error_cnt, n_checks;

    vsp_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vertical_sync_in(vertical_sync_in),
        .serial_irq_req(serial_irq_req), .serial_irq_enable(serial_irq_enable),
        .shared_irq(shared_irq), .shared_irq_vector(shared_irq_vector), .pwm_raw(pwm_raw),
        .pwm_channel_eight(pwm_channel_eight), .pwm_out(pwm_out), .pwm_eight_out(pwm_eight_out),
        .blink_visible(blink_visible), .evt_irq(evt_irq));
    vsp_cpu_side u_cpu (.core_clk(core_clk), .vertical_sync_in(vertical_sync_in),
        .serial_irq_req(serial_irq_req));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Request held until the edge where ready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk("ready wait", 32'h1, 32'h0);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel twice at once
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, idx, d, q, e);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        logic        e;
        apb(1'b0, idx, 8'h00, q, e);
        chk(nm, exp, q);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] q;
        logic        e;
        int          vis;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        serial_irq_enable = 1'b0;
        pwm_raw = 8'h00;
        pwm_channel_eight = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        cyc(4);
        sys_rst <= 1'b0;
        cyc(1);
        rd(`VSP_IDX_SYNC_PWM, 32'h00, "pol reset");
        rd(`VSP_IDX_BLINK, 32'h03, "blink reset");
        rd(`VSP_IDX_SYNC_POL, 32'h00, "vpol reset");
        apb(1'b0, 8'hFF, 8'h00, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        chk("vector", 32'h05, {24'h0, shared_irq_vector});
        wr(`VSP_IDX_SYNC_PWM, 8'hFF);
        rd(`VSP_IDX_SYNC_PWM, 32'hC7, "reserved pol");
        wr(`VSP_IDX_BLINK, 8'hFF);
        rd(`VSP_IDX_BLINK, 32'h0F, "reserved blink");
        // Lane 0 off drops the write, lane 0 on lands it
        for (int s = 0; s < 2; s++)
        begin
            pstrb <= 4'(4'hE | s);
            wr(`VSP_IDX_EVT_MASK, 8'h02);
            rd(`VSP_IDX_EVT_MASK, 32'(2 * s), "lane0 strobe");
        end
        for (int i = 0; i < 8; i++)
        begin
            pwm_raw <= 8'hA5 ^ 8'(i * 17);
            pwm_channel_eight <= i[1];
            wr(`VSP_IDX_SYNC_PWM, 8'(i));
            cyc(2);
            chk("pwm out", {24'h0, 8'hA5 ^ 8'(i * 17) ^ {{4{i[0]}}, {4{i[1]}}}}, {24'h0, pwm_out});
            chk("pwm eight", {31'h0, i[1] ^ i[2]}, {31'h0, pwm_eight_out});
        end
        wr(`VSP_IDX_SYNC_PWM, 8'h40);
        serial_irq_enable <= 1'b1;
        u_cpu.set_serial(1'b1);
        cyc(3);
        chk("serial irq", 32'h1, {31'h0, shared_irq});
        rd(`VSP_IDX_SYNC_PWM, 32'h40, "source serial");
        u_cpu.set_serial(1'b0);
        cyc(3);
        chk("serial idle", 32'h0, {31'h0, shared_irq});
        // A polarity change may fake an edge, so clear before judging
        for (int p = 0; p < 2; p++)
        begin
            wr(`VSP_IDX_SYNC_POL, 8'(p << 2));
            u_cpu.set_sync(~p[0]);
            cyc(8);
            wr(`VSP_IDX_SYNC_PWM, 8'h40);
            cyc(3);
            chk("idle irq", 32'h0, {31'h0, shared_irq});
            u_cpu.set_sync(p[0]);
            cyc(8);
            chk("sync irq", 32'h1, {31'h0, shared_irq});
            rd(`VSP_IDX_SYNC_PWM, 32'hC0, "source sync");
            wr(`VSP_IDX_SYNC_PWM, 8'h40);
            cyc(3);
            chk("cleared irq", 32'h0, {31'h0, shared_irq});
            u_cpu.set_sync(~p[0]);
            cyc(8);
            chk("inactive edge", 32'h0, {31'h0, shared_irq});
        end
        wr(`VSP_IDX_SYNC_PWM, 8'h00);
        u_cpu.pulse(1'b1);
        chk("sync disabled", 32'h0, {31'h0, shared_irq});
        serial_irq_enable <= 1'b0;
        wr(`VSP_IDX_SYNC_PWM, 8'h40);
        u_cpu.pulse(1'b1);
        chk("serial disabled", 32'h0, {31'h0, shared_irq});
        rd(`VSP_IDX_SYNC_PWM, 32'h40, "flag stays clear");
        for (int r = 0; r < 4; r++)
            for (int f = 0; f < 4; f++)
            begin
                wr(`VSP_IDX_BLINK, 8'hF0 | 8'((r << 2) | f));
                vis = 0;
                repeat (128) u_cpu.pulse(1'b1);
                repeat (16 << f)
                begin
                    u_cpu.pulse(1'b1);
                    vis += (blink_visible === 1'b1);
                end
                chk("visible edges", 32'(((16 << f) * ((r == 3) ? 2 : 3 - r)) / 4), 32'(vis));
            end
        wr(`VSP_IDX_EVT_MASK, 8'h01);
        apb(1'b0, `VSP_IDX_EVT_STATUS, 8'h00, q, e);
        cyc(2);
        chk("evt cleared", 32'h0, {31'h0, evt_irq});
        wr(`VSP_IDX_EVT_MASK, 8'h00);
        u_cpu.pulse(1'b1);
        chk("evt masked", 32'h0, {31'h0, evt_irq});
        wr(`VSP_IDX_EVT_MASK, 8'h01);
        cyc(2);
        chk("evt raised", 32'h1, {31'h0, evt_irq});
        apb(1'b0, `VSP_IDX_EVT_STATUS, 8'h00, q, e);
        chk("evt status", 32'h1, q & 32'h1);
        cyc(2);
        chk("evt read clear", 32'h0, {31'h0, evt_irq});
        report_and_stop();
    end
endmodule

bind vsp_top vsp_top_chk #(.PWM_N(PWM_N)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_irq_req(serial_irq_req), .serial_irq_enable(serial_irq_enable), .shared_irq(shared_irq),
    .shared_irq_vector(shared_irq_vector), .pwm_raw(pwm_raw), .pwm_out(pwm_out),
    .blink_visible(blink_visible), .evt_irq(evt_irq));
`default_nettype wire
